// ---- verilog/nsd_pkg.sv ----
package nsd_pkg;

  // APB address width and register byte offsets
  localparam int          APB_AW        = 8;
  localparam logic [7:0]  OFS_CLKDIV    = 8'h00;
  localparam logic [7:0]  OFS_CONFIG    = 8'h04;
  localparam logic [7:0]  OFS_STATUS    = 8'h08;
  localparam logic [7:0]  OFS_PARAM_IDX = 8'h0C;
  localparam logic [7:0]  OFS_CCOB      = 8'h10;
  localparam logic [7:0]  OFS_ERRSTAT   = 8'h14;
  localparam logic [7:0]  OFS_ERRCNFG   = 8'h18;
  localparam logic [7:0]  OFS_EVTSTAT   = 8'h1C;
  localparam logic [7:0]  OFS_EVTMASK   = 8'h20;

  // Clock divider register fields
  localparam int          DIV_LOADED_BIT = 7;
  localparam int          DIV_LOCK_BIT   = 6;
  localparam int          DIV_W          = 6;
  localparam logic [5:0]  DIV_RESET      = 6'h00;

  // Config register: command complete interrupt enable
  localparam int          CFG_DONE_IE_BIT = 7;

  // Status register fields
  localparam int          ST_DONE_BIT    = 7;
  localparam int          ST_ACC_ERR_BIT = 5;
  localparam int          ST_PROT_BIT    = 4;
  localparam int          ST_MG1_BIT     = 1;
  localparam int          ST_MG0_BIT     = 0;

  // ECC error status and config fields
  localparam int          ERR_DBL_BIT    = 1;
  localparam int          ERR_SGL_BIT    = 0;

  // Event status / mask layout
  localparam int          EVT_W          = 3;
  localparam int          EVT_DONE_BIT   = 0;
  localparam int          EVT_DBL_BIT    = 1;
  localparam int          EVT_SGL_BIT    = 2;

  // Command parameter object
  localparam int          IDX_W          = 3;
  localparam int          CCOB_WORDS     = 6;
  localparam int          ADDR_W         = 18;
  localparam logic [7:0]  CMD_SECT_ERASE = 8'h12;
  localparam logic [2:0]  IDX_ERASE_LAST = 3'h1;
  localparam logic [2:0]  IDX_CMD_WORD   = 3'h0;
  localparam logic [2:0]  IDX_ADDR_WORD  = 3'h1;

  // Divider tick target and erase pulse length
  localparam int          TICK_TIME_NS   = 1000;
  localparam int          SYS_CLK_NS     = 4;
  localparam int          ERASE_TIME_US  = 5;
  localparam int          ERASE_TICKS    = (ERASE_TIME_US * 1000) / TICK_TIME_NS;

  // Sequencer states
  typedef enum logic [3:0] {
    NSD_IDLE   = 4'b0001,
    NSD_ERASE  = 4'b0010,
    NSD_VERIFY = 4'b0100,
    NSD_FINISH = 4'b1000
  } nsd_state_t;

endpackage : nsd_pkg

// ---- verilog/nsd_tick_div.sv ----
`timescale 1ns/1ps
`default_nettype none

module nsd_tick_div #(
  parameter int DW = 6
) (
  input  wire logic          sys_clk,
  input  wire logic          reset,
  input  wire logic          run,
  input  wire logic [DW-1:0] ratio,
  output logic               tick
);
  import nsd_pkg::*;

  logic [DW-1:0] cnt_r;

  // Divide by ratio+1; held cleared until the divider has been loaded
  always_ff @(posedge sys_clk) begin
    if (reset || !run) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (cnt_r >= ratio) begin
      cnt_r <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule : nsd_tick_div

`default_nettype wire

// ---- verilog/nsd_top.sv ----
//
// Contract
// - Loaded bit reads one after any write
// - Lock bit freezes divide field until reset
// - Loaded bit unwritable; special mode rewrites freely
// - Launch erases, verifies, then sets complete flag
// - Access error unless index is 001 at launch
// - Access error when command unavailable in mode
// - Access error on invalid EEPROM global address
// - Access error on odd word address
// - Protection violation instead of erasing protected area
// - Upper verify bit on any verify error
// - Lower verify bit on uncorrectable verify error
// - Complete interrupt when flag and enable set
// - Double fault interrupt when flag and enable
// - Single fault interrupt when flag and enable
`timescale 1ns/1ps
`default_nettype none

module nsd_top #(
  parameter logic [17:0] EE_LO       = 18'h00400,
  parameter logic [17:0] EE_HI       = 18'h013FF,
  parameter int          ERASE_TCNT  = nsd_pkg::ERASE_TICKS
) (
  input  wire logic                           sys_clk,
  input  wire logic                           reset,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [nsd_pkg::APB_AW-1:0]     paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           special_mode,
  input  wire logic                           ee_prot_en,
  input  wire logic [nsd_pkg::ADDR_W-1:0]     ee_prot_base,
  input  wire logic                           ecc_dbl_fault,
  input  wire logic                           ecc_sgl_fault,
  output logic                                arr_erase,
  output logic                                arr_verify,
  output logic      [nsd_pkg::ADDR_W-1:0]     arr_addr,
  input  wire logic                           verify_done,
  input  wire logic                           verify_fail,
  input  wire logic                           verify_uncorr,
  output logic                                tick_1mhz,
  output logic                                irq_cmd,
  output logic                                irq_ecc,
  output logic                                irq_evt
);
  import nsd_pkg::*;

  localparam int TCW = $clog2(ERASE_TCNT + 1);
  localparam logic [TCW-1:0] TCNT_LAST = TCW'(ERASE_TCNT - 1);

  // Register state
  logic              loaded_r;
  logic              lock_r;
  logic [DIV_W-1:0]  ratio_r;
  logic              done_ie_r;
  logic              done_flag_r;
  logic              acc_err_r;
  logic              prot_viol_r;
  logic              mg1_r;
  logic              mg0_r;
  logic [IDX_W-1:0]  idx_r;
  logic [15:0]       ccob_r [CCOB_WORDS];
  logic              dbl_flag_r;
  logic              sgl_flag_r;
  logic              dbl_ie_r;
  logic              sgl_ie_r;
  logic [EVT_W-1:0]  evt_r;
  logic [EVT_W-1:0]  evt_mask_r;
  nsd_state_t        state_r;
  logic [TCW-1:0]    tcnt_r;
  logic              tick;

  // APB phases: no wait states, the access completes when pready is high
  logic setup;
  logic wr_done;
  logic rd_done;
  assign setup   = psel && !penable;
  assign wr_done = psel && penable && pready && pwrite;
  assign rd_done = psel && penable && pready && !pwrite;

  logic [ADDR_W-1:0] gaddr;
  logic [7:0]        cmd_code;
  logic              chk_acc;
  logic              chk_prot;
  logic              launch;
  logic              done_evt;
  assign gaddr    = {ccob_r[IDX_CMD_WORD][1:0], ccob_r[IDX_ADDR_WORD]};
  assign cmd_code = ccob_r[IDX_CMD_WORD][15:8];

  // Launch: write 1 to the complete flag while idle and no error is pending
  assign launch = wr_done && (paddr == OFS_STATUS) && pwdata[ST_DONE_BIT] && done_flag_r && !acc_err_r && !prot_viol_r;

  // Launch checks; an unloaded divider means no timebase, so the command is unavailable
  assign chk_acc = (idx_r != IDX_ERASE_LAST)
                 || (cmd_code != CMD_SECT_ERASE) || !loaded_r
                 || (gaddr < EE_LO) || (gaddr > EE_HI)
                 || gaddr[0];
  assign chk_prot = ee_prot_en && (gaddr >= ee_prot_base);

  assign done_evt = (state_r == NSD_FINISH);

  // Timebase for the erase pulse
  nsd_tick_div #(
    .DW    (DIV_W)
  ) u_div (
    .sys_clk (sys_clk),
    .reset   (reset),
    .run     (loaded_r),
    .ratio   (ratio_r),
    .tick    (tick)
  );

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tick_1mhz <= 1'b0;
    end else begin
      tick_1mhz <= tick;
    end
  end

  // Clock divider register; software must not write it mid-command
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      loaded_r <= 1'b0;
      lock_r   <= 1'b0;
      ratio_r  <= DIV_RESET;
    end else if (wr_done && paddr == OFS_CLKDIV) begin
      loaded_r <= 1'b1;
      if (special_mode) begin
        lock_r  <= pwdata[DIV_LOCK_BIT];
        ratio_r <= pwdata[DIV_W-1:0];
      end else if (!lock_r) begin
        lock_r  <= pwdata[DIV_LOCK_BIT];
        ratio_r <= pwdata[DIV_W-1:0];
      end
    end
  end

  // Config registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      done_ie_r  <= 1'b0;
      dbl_ie_r   <= 1'b0;
      sgl_ie_r   <= 1'b0;
      evt_mask_r <= '0;
    end else if (wr_done) begin
      if (paddr == OFS_CONFIG) begin
        done_ie_r <= pwdata[CFG_DONE_IE_BIT];
      end
      if (paddr == OFS_ERRCNFG) begin
        dbl_ie_r <= pwdata[ERR_DBL_BIT];
        sgl_ie_r <= pwdata[ERR_SGL_BIT];
      end
      if (paddr == OFS_EVTMASK) begin
        evt_mask_r <= pwdata[EVT_W-1:0];
      end
    end
  end

  // Parameter index and object; frozen while a command runs
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      idx_r <= '0;
    end else if (wr_done && paddr == OFS_PARAM_IDX && done_flag_r) begin
      idx_r <= pwdata[IDX_W-1:0];
    end
  end

  for (genvar i = 0; i < CCOB_WORDS; i++) begin : g_ccob
    always_ff @(posedge sys_clk) begin
      if (reset) begin
        ccob_r[i] <= 16'h0000;
      end else if (wr_done && paddr == OFS_CCOB && done_flag_r && idx_r == IDX_W'(i)) begin
        ccob_r[i] <= pwdata[15:0];
      end
    end
  end

  // Command status flags; a hardware set wins over a same-cycle software clear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      done_flag_r <= 1'b1;
      acc_err_r   <= 1'b0;
      prot_viol_r <= 1'b0;
      mg1_r       <= 1'b0;
      mg0_r       <= 1'b0;
    end else begin
      if (wr_done && paddr == OFS_STATUS) begin
        if (pwdata[ST_ACC_ERR_BIT]) begin
          acc_err_r <= 1'b0;
        end
        if (pwdata[ST_PROT_BIT]) begin
          prot_viol_r <= 1'b0;
        end
      end
      if (launch) begin
        mg1_r <= 1'b0;
        mg0_r <= 1'b0;
        if (chk_acc) begin
          acc_err_r <= 1'b1;
        end else if (chk_prot) begin
          prot_viol_r <= 1'b1;
        end else begin
          done_flag_r <= 1'b0;
        end
      end
      if (state_r == NSD_VERIFY && verify_done) begin
        mg1_r <= verify_fail || verify_uncorr;
        mg0_r <= verify_uncorr;
      end
      if (done_evt) begin
        done_flag_r <= 1'b1;
      end
    end
  end

  // Erase sequencer: timed erase pulse, then verify handshake with the array
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r    <= NSD_IDLE;
      tcnt_r     <= '0;
      arr_erase  <= 1'b0;
      arr_verify <= 1'b0;
      arr_addr   <= '0;
    end else begin
      case (state_r)
        NSD_IDLE: begin
          if (launch && !chk_acc && !chk_prot) begin
            state_r   <= NSD_ERASE;
            tcnt_r    <= '0;
            arr_erase <= 1'b1;
            arr_addr  <= gaddr;
          end
        end
        NSD_ERASE: begin
          if (tick) begin
            if (tcnt_r == TCNT_LAST) begin
              state_r    <= NSD_VERIFY;
              arr_erase  <= 1'b0;
              arr_verify <= 1'b1;
            end else begin
              tcnt_r <= tcnt_r + 1'b1;
            end
          end
        end
        NSD_VERIFY: begin
          if (verify_done) begin
            state_r    <= NSD_FINISH;
            arr_verify <= 1'b0;
          end
        end
        NSD_FINISH: begin
          state_r <= NSD_IDLE;
        end
        default: begin
          state_r    <= NSD_IDLE;
          arr_erase  <= 1'b0;
          arr_verify <= 1'b0;
        end
      endcase
    end
  end

  // ECC fault flags, write 1 to clear; a fault in the clearing cycle survives
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dbl_flag_r <= 1'b0;
      sgl_flag_r <= 1'b0;
    end else begin
      dbl_flag_r <= ecc_dbl_fault || (dbl_flag_r && !(wr_done && paddr == OFS_ERRSTAT && pwdata[ERR_DBL_BIT]));
      sgl_flag_r <= ecc_sgl_fault || (sgl_flag_r && !(wr_done && paddr == OFS_ERRSTAT && pwdata[ERR_SGL_BIT]));
    end
  end

  // Sticky event bits, cleared by reading them
  logic [EVT_W-1:0] evt_set;
  assign evt_set = {ecc_sgl_fault, ecc_dbl_fault, done_evt};

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      evt_r <= '0;
    end else if (rd_done && paddr == OFS_EVTSTAT) begin
      evt_r <= (evt_r & ~prdata[EVT_W-1:0]) | evt_set; // Clears only what this read reported
    end else begin
      evt_r <= evt_r | evt_set;
    end
  end

  // Level interrupt requests, registered; they follow flag and enable
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_cmd <= 1'b0;
      irq_ecc <= 1'b0;
      irq_evt <= 1'b0;
    end else begin
      irq_cmd <= done_flag_r && done_ie_r;
      irq_ecc <= (dbl_flag_r && dbl_ie_r)
              || (sgl_flag_r && sgl_ie_r);
      irq_evt <= |(evt_r & evt_mask_r);
    end
  end

  // Read mux, sampled in the setup cycle
  logic [31:0] rd_val;
  logic        rd_hit;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      OFS_CLKDIV: begin
        rd_val[DIV_LOADED_BIT] = loaded_r;
        rd_val[DIV_LOCK_BIT]   = lock_r;
        rd_val[DIV_W-1:0]      = ratio_r;
      end
      OFS_CONFIG: begin
        rd_val[CFG_DONE_IE_BIT] = done_ie_r;
      end
      OFS_STATUS: begin
        rd_val[ST_DONE_BIT]    = done_flag_r;
        rd_val[ST_ACC_ERR_BIT] = acc_err_r;
        rd_val[ST_PROT_BIT]    = prot_viol_r;
        rd_val[ST_MG1_BIT]    = mg1_r;
        rd_val[ST_MG0_BIT]    = mg0_r;
      end
      OFS_PARAM_IDX: begin
        rd_val[IDX_W-1:0] = idx_r;
      end
      OFS_CCOB: begin
        if (idx_r < IDX_W'(CCOB_WORDS)) begin
          rd_val[15:0] = ccob_r[idx_r];
        end
      end
      OFS_ERRSTAT: begin
        rd_val[ERR_DBL_BIT] = dbl_flag_r;
        rd_val[ERR_SGL_BIT] = sgl_flag_r;
      end
      OFS_ERRCNFG: begin
        rd_val[ERR_DBL_BIT] = dbl_ie_r;
        rd_val[ERR_SGL_BIT] = sgl_ie_r;
      end
      OFS_EVTSTAT: begin
        rd_val[EVT_W-1:0] = evt_r;
      end
      OFS_EVTMASK: begin
        rd_val[EVT_W-1:0] = evt_mask_r;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // APB answer: ready one cycle after setup, for exactly one cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (setup) begin
      pready  <= 1'b1;
      pslverr <= !rd_hit;
      prdata  <= pwrite ? 32'h0000_0000 : rd_val;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

endmodule : nsd_top

`default_nettype wire

// ---- verif/nsd_top_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

module nsd_top_monitor
  import nsd_pkg::*;
#(
  parameter logic [17:0] EE_LO = 18'h00400,
  parameter logic [17:0] EE_HI = 18'h013FF
) (
  input wire logic               sys_clk,
  input wire logic               reset,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [APB_AW-1:0]  paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               special_mode,
  input wire logic               ee_prot_en,
  input wire logic [ADDR_W-1:0]  ee_prot_base,
  input wire logic               ecc_dbl_fault,
  input wire logic               ecc_sgl_fault,
  input wire logic               arr_erase,
  input wire logic               arr_verify,
  input wire logic [ADDR_W-1:0]  arr_addr,
  input wire logic               verify_done,
  input wire logic               verify_fail,
  input wire logic               verify_uncorr,
  input wire logic               tick_1mhz,
  input wire logic               irq_cmd,
  input wire logic               irq_ecc,
  input wire logic               irq_evt
);
  logic acc;
  logic div_wr_r;

  // Completed APB access phase
  assign acc = psel && penable && pready;

  // Remembers a divider write since reset, to judge the loaded bit
  always_ff @(posedge sys_clk) begin
    if (reset) div_wr_r <= 1'b0;
    else if (acc && pwrite && paddr == OFS_CLKDIV) div_wr_r <= 1'b1;
  end

  default clocking mon_cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_loaded_reads_back: assert property (acc && !pwrite && paddr == OFS_CLKDIV |-> prdata[7] == div_wr_r)
    else $error("divider loaded bit disagrees with write history");
  a_launch_starts_erase: assert property ($rose(arr_erase) |->
    $past(acc && pwrite && paddr == OFS_STATUS && pwdata[ST_DONE_BIT])) else $error("erase began without launch");
  a_erase_then_verify: assert property ($fell(arr_erase) |-> arr_verify)
    else $error("verify did not follow erase");
  a_verify_ends: assert property (arr_verify && verify_done |=> !arr_verify)
    else $error("verify kept running after done");
  a_no_protected_erase: assert property ($rose(arr_erase) |-> !(ee_prot_en && arr_addr >= ee_prot_base))
    else $error("protected sector erased");
  a_erase_addr_valid: assert property (arr_erase |-> arr_addr inside {[EE_LO:EE_HI]} && !arr_addr[0])
    else $error("erase on invalid or odd address");
  a_cmd_irq_cause: assert property ($rose(irq_cmd) |-> $past(arr_verify && verify_done, 3) ||
    $past(acc && pwrite && paddr == OFS_CONFIG, 2)) else $error("command irq rose without cause");
  a_launch_drops_irq: assert property ($rose(arr_erase) |=> !irq_cmd)
    else $error("command irq held after launch");
  a_ecc_irq_cause: assert property ($rose(irq_ecc) |-> $past(ecc_dbl_fault || ecc_sgl_fault, 2) ||
    $past(acc && pwrite && paddr == OFS_ERRCNFG, 2)) else $error("ecc irq rose without cause");
endmodule : nsd_top_monitor

bind nsd_top nsd_top_monitor #(.EE_LO(EE_LO), .EE_HI(EE_HI)) nsd_top_monitor_i (.*);

`default_nettype wire

// ---- verif/nsd_top_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module nsd_top_tb_top;
  import nsd_pkg::*;
  logic        sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, seed = 32'h0000CAB5;
  logic        special_mode = 1'b0, ee_prot_en = 1'b0, ecc_dbl_fault = 1'b0, ecc_sgl_fault = 1'b0;
  logic        verify_done = 1'b0, verify_fail = 1'b0, verify_uncorr = 1'b0;
  logic [17:0] ee_prot_base = 18'h3FFFF, arr_addr, a;
  logic        arr_erase, arr_verify, tick_1mhz, irq_cmd, irq_ecc, irq_evt;
  int          bad_count = 0, total_checks = 0, cyc = 0;
  logic [7:0]  ec [5] = '{8'h12, 8'h11, 8'h12, 8'h12, 8'h12};
  logic [17:0] ea [5] = '{18'h00402, 18'h00402, 18'h00200, 18'h00403, 18'h01000};
  logic [2:0]  ei [5] = '{3'h2, 3'h1, 3'h1, 3'h1, 3'h1};

  // Short erase so a run stays brief
  nsd_top #(.ERASE_TCNT(2)) nsd_top_i (.*);

  // Clock at 250 MHz
  always #2 sys_clk = ~sys_clk;

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; waits for pready with no bound of its own, samples at that edge
  task automatic apb(input logic [7:0] ad, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(ad, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [31:0] ex);
    apb(ad, 1'b0, 32'h0);
    chk(q, ex);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : settle

  // Spacing of two tick pulses in clock cycles; the hang guard bounds the wait
  task automatic tick_gap(input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge sys_clk);
    while (tick_1mhz !== 1'b1) @(posedge sys_clk);
    do begin
      @(posedge sys_clk);
      n++;
    end while (tick_1mhz !== 1'b1);
    chk(n, exp);
  endtask : tick_gap

  // Fill the parameter words, set the final index, then launch
  task automatic load(input logic [7:0] cmd, input logic [17:0] ad, input logic [2:0] ix);
    wr(OFS_PARAM_IDX, 32'h0);
    wr(OFS_CCOB, {16'h0, cmd, 6'h0, ad[17:16]});
    wr(OFS_PARAM_IDX, 32'h1);
    wr(OFS_CCOB, {16'h0, ad[15:0]});
    wr(OFS_PARAM_IDX, {29'h0, ix});
    wr(OFS_STATUS, 32'h80);
  endtask : load

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(OFS_CLKDIV, 32'h0);
    rd(OFS_STATUS, 32'h80);
    apb(8'h24, 1'b0, 32'h0);
    chk({q[30:0], e}, 32'h1);
    a = 18'(rnd());
    wr(OFS_CLKDIV, {26'h0, a[5:0]});
    rd(OFS_CLKDIV, {24'h0, 2'b10, a[5:0]});
    tick_gap({26'h0, a[5:0]} + 32'h1);
    wr(OFS_CLKDIV, 32'h42);
    wr(OFS_CLKDIV, 32'h05);
    rd(OFS_CLKDIV, 32'hC2);
    special_mode <= 1'b1;
    wr(OFS_CLKDIV, 32'h01);
    rd(OFS_CLKDIV, 32'h81);
    special_mode <= 1'b0;
    wr(OFS_CONFIG, 32'h80);
    settle(3);
    chk({31'h0, irq_cmd}, 32'h1);
    wr(OFS_CONFIG, 32'h0);
    settle(3);
    chk({31'h0, irq_cmd}, 32'h0);
    wr(OFS_CONFIG, 32'h80);
    // Refused launches: flag stays set, error flags cleared after
    for (int i = 0; i < 5; i++) begin
      ee_prot_en <= (i == 4);
      ee_prot_base <= 18'h00800;
      load(ec[i], ea[i], ei[i]);
      rd(OFS_STATUS, i == 4 ? 32'h90 : 32'hA0);
      wr(OFS_STATUS, 32'h30);
    end
    ee_prot_en <= 1'b0;
    // Good erases with each verify outcome
    for (int i = 0; i < 3; i++) begin
      a = 18'h00400 + 18'(rnd() & 32'h00000FFE);
      load(8'h12, a, 3'h1);
      rd(OFS_STATUS, 32'h0);
      for (int k = 0; k < 100 && arr_verify !== 1'b1; k++) settle(1);
      chk({14'h0, arr_addr}, {14'h0, a});
      verify_done <= 1'b1;
      verify_fail <= (i > 0);
      verify_uncorr <= (i > 1);
      settle(1);
      verify_done <= 1'b0;
      settle(4);
      rd(OFS_STATUS, 32'h80 | (i > 0 ? 32'h2 : 32'h0) | (i > 1 ? 32'h1 : 32'h0));
      chk({31'h0, irq_cmd}, 32'h1);
    end
    wr(OFS_EVTMASK, 32'h1);
    settle(2);
    chk({31'h0, irq_evt}, 32'h1);
    rd(OFS_EVTSTAT, 32'h1);
    settle(2);
    chk({31'h0, irq_evt}, 32'h0);
    // ECC faults raise, then a clear drops the level
    wr(OFS_ERRCNFG, 32'h3);
    for (int i = 0; i < 2; i++) begin
      ecc_dbl_fault <= (i == 0);
      ecc_sgl_fault <= (i == 1);
      settle(1);
      ecc_dbl_fault <= 1'b0;
      ecc_sgl_fault <= 1'b0;
      settle(2);
      chk({31'h0, irq_ecc}, 32'h1);
      rd(OFS_ERRSTAT, i ? 32'h1 : 32'h2);
      wr(OFS_ERRSTAT, i ? 32'h1 : 32'h2);
      settle(2);
      chk({31'h0, irq_ecc}, 32'h0);
    end
    rd(OFS_EVTSTAT, 32'h6);
    give_verdict();
  end
endmodule : nsd_top_tb_top

`default_nettype wire
